/* File: design/cpu_exec_core.sv */
`timescale 1ns/1ps
`include "cpu_exec_defines.svh"
// Summary of operation
// - Each flag computed, kept or forced per instruction.
// - Add stores sum, computes flags, clears D.
// - Add-with-carry adds carry; extended forms 18, 19.
// - Subtract-with-borrow subtracts carry, sets D.
// - Logic ops set Z, S, clear V only.
// - Multiply pair bytes into pair, eight execute cycles.
// - Decrement register, branch relative when nonzero.
// - Conditional jump loads absolute address if true.
// - Conditional relative jump adds displacement if true.
// - Interrupt return pops flags, PC, enables interrupts.
// - Trap pushes PC, flags, loads vector word.
// - Return pops PC, stack pointer plus two.
// - Pop reads stack byte, then increments pointer.
// - Push decrements pointer, then writes byte.
// - Block moves copy byte, increment both pointers.
// - Rotate left through carry, flags computed.
// - Logical shift right inserts zero, clears S.
// - Arithmetic shift right keeps bit 7, clears V.
// - Rotate right copies bit 0 to bit 7, carry.
// - Branch condition is opcode bits 7:4.
module cpu_exec_core (
  input wire logic clk_in, // 100 MHz clock.
  input wire logic rst_in, // Synchronous reset, active high.
  input wire logic ce_in, // Clock enable; low freezes all state.
  input wire logic [7:0] address_in, // Avalon byte address.
  input wire logic read_in, // Avalon read request.
  input wire logic write_in, // Avalon write request.
  input wire logic [31:0] writedata_in, // Avalon write data.
  output logic [31:0] readdata_out, // Avalon read data, registered.
  output logic waitrequest_out, // Avalon wait request.
  output logic busy_out // High while an instruction runs.
);

  cpu_exec_pkg::state_t q;
  cpu_exec_pkg::state_t n;

  // Condition test on the flags; the field is the opcode's upper nibble.
  function automatic logic cond_true(input logic [3:0] cc, input logic [5:0] f);
    logic c;
    logic z;
    logic s;
    logic v;
    logic t;
    c = f[`FLG_C];
    z = f[`FLG_Z];
    s = f[`FLG_S];
    v = f[`FLG_V];
    case (cc[2:0])
      3'd0: t = 1'b0;
      3'd1: t = s ^ v;
      3'd2: t = z | (s ^ v);
      3'd3: t = c | z;
      3'd4: t = v;
      3'd5: t = s;
      3'd6: t = z;
      default: t = c;
    endcase
    cond_true = cc[3] ? ~t : t;
  endfunction

  // Returns {legal, fetch cycles, execute cycles} for a decoded opcode.
  function automatic logic [8:0] timing(input logic [7:0] op, input logic pfx);
    logic [3:0] hi;
    logic [3:0] lo;
    logic [8:0] r;
    hi = op[7:4];
    lo = op[3:0];
    r = {1'b0, 4'd1, `CYC_ILLEGAL_EX};
    if (pfx) begin
      if (op == `OPC_SHL_LO || op == `OPC_SHL_HI) begin
        r = {1'b1, 4'd3, (op[0] ? 4'd3 : 4'd2)};
      end
    end else if (lo >= 4'd2 && lo <= 4'd9 &&
                 (hi <= 4'd5 || hi == 4'hB) && !(hi == 4'd0 && lo == 4'd1)) begin
      if (lo <= 4'd3) begin
        r = {1'b1, 4'd2, (lo[0] ? 4'd4 : 4'd3)};
      end else if (lo <= 4'd7) begin
        r = {1'b1, 4'd3, (lo[0] ? 4'd4 : 4'd3)};
      end else begin
        r = {1'b1, 4'd4, 4'd3};
      end
    end else if (lo == 4'hA) begin
      r = {1'b1, 4'd2, 4'd3};
    end else if (lo == 4'hB) begin
      r = {1'b1, 4'd2, 4'd2};
    end else if (lo == 4'hD) begin
      r = {1'b1, 4'd3, 4'd2};
    end else begin
      case (op)
        `BYTE_MULTIPLY_OP: r = {1'b1, 4'd2, `CYC_MULTIPLY_EX};
        `INTERRUPT_RETURN_OP: r = {1'b1, 4'd1, `CYC_INT_RETURN_EX};
        `OPC_TRAP: r = {1'b1, 4'd2, `CYC_TRAP_EX};
        `SUBROUTINE_RETURN_OP: r = {1'b1, 4'd1, `CYC_SUB_RETURN_EX};
        `OPC_POP, `OPC_PUSH: r = {1'b1, 4'd2, 4'd2};
        `OPC_POP_IND, `OPC_PUSH_IND: r = {1'b1, 4'd2, 4'd3};
        `EXTENDED_POP_OP, `EXTENDED_PUSH_OP: r = {1'b1, 4'd3, 4'd2};
        `OPC_PMOVE_TO, `OPC_PMOVE_FROM,
        `OPC_DMOVE_TO, `OPC_DMOVE_FROM: r = {1'b1, 4'd2, `CYC_MOVE_EX};
        8'h10, 8'h11, 8'hD0, 8'hD1, 8'hE0, 8'hE1: r = {1'b1, 4'd2, (op[0] ? 4'd3 : 4'd2)};
        default: r = {1'b0, 4'd1, `CYC_ILLEGAL_EX};
      endcase
    end
    timing = r;
  endfunction

  // Next-state logic: bus slave, sequencer and instruction effects.
  always_comb begin
    logic [3:0] hi;
    logic [3:0] lo;
    logic [3:0] ra;
    logic [3:0] rb;
    logic [3:0] rp;
    logic [7:0] d;
    logic [7:0] s;
    logic [7:0] r;
    logic [8:0] w9;
    logic [4:0] h5;
    logic cin;
    logic [15:0] prod;
    logic [15:0] addr;
    logic [15:0] sp_t;
    logic [8:0] tm;
    logic [7:0] roff;
    logic [31:0] rv;
    n = q;
    hi = q.opc[7:4];
    lo = q.opc[3:0];
    ra = q.opa[7:4];
    rb = q.opa[3:0];
    rp = {rb[3:1], 1'b0};
    d = 8'h00;
    s = 8'h00;
    r = 8'h00;
    w9 = 9'h000;
    h5 = 5'h00;
    cin = 1'b0;
    prod = 16'h0000;
    addr = 16'h0000;
    sp_t = 16'h0000;
    tm = timing(q.opc, q.pfx);
    roff = address_in & ~`WIN_MASK;
    rv = 32'h0000_0000;
    n.ack = 1'b0;

    // Sequencer: fetch count, then execute count, effects at the end.
    case (q.fsm)
      cpu_exec_pkg::S_FETCH: begin
        if (q.cnt == 4'd0) begin
          n.fsm = cpu_exec_pkg::S_EXEC;
          n.cnt = q.exec_cnt - 4'd1;
        end else begin
          n.cnt = q.cnt - 4'd1;
        end
      end
      cpu_exec_pkg::S_EXEC: begin
        if (q.cnt != 4'd0) begin
          n.cnt = q.cnt - 4'd1;
        end else begin
          n.fsm = cpu_exec_pkg::S_IDLE;
          n.done = 1'b1;
          if (q.pfx) begin
            // Logical shift right, register or indirect operand.
            d = q.opc[0] ? q.mem[q.wreg[ra][3:0]] : q.wreg[ra];
            r = {1'b0, d[7:1]};
            n.flags[`FLG_C] = d[0];
            n.flags[`FLG_Z] = (r == 8'h00);
            n.flags[`FLG_S] = 1'b0;
            n.flags[`FLG_V] = d[7] ^ r[7];
            if (q.opc[0]) n.mem[q.wreg[ra][3:0]] = r;
            else n.wreg[ra] = r;
          end else if (tm[7:4] != 4'd1 && lo >= 4'd2 && lo <= 4'd9 && (hi <= 4'd5 || hi == 4'hB)) begin
            // Two-operand arithmetic and logic group.
            d = q.wreg[ra];
            if (lo == 4'd2) s = q.wreg[rb];
            else if (lo == 4'd3) s = q.mem[q.wreg[rb][3:0]];
            else s = q.opb;
            cin = (hi == 4'd1 || hi == 4'd3) ? q.flags[`FLG_C] : 1'b0;
            if (hi <= 4'd1) begin
              w9 = {1'b0, d} + {1'b0, s} + {8'h00, cin};
              h5 = {1'b0, d[3:0]} + {1'b0, s[3:0]} + {4'h0, cin};
              r = w9[7:0];
              n.flags[`FLG_V] = (d[7] == s[7]) && (r[7] != d[7]);
              n.flags[`FLG_D] = 1'b0;
            end else if (hi <= 4'd3) begin
              w9 = {1'b0, d} - {1'b0, s} - {8'h00, cin};
              h5 = {1'b0, d[3:0]} - {1'b0, s[3:0]} - {4'h0, cin};
              r = w9[7:0];
              n.flags[`FLG_V] = (d[7] != s[7]) && (r[7] != d[7]);
              n.flags[`FLG_D] = 1'b1;
            end else begin
              if (hi == 4'd5) r = d & s;
              else if (hi == 4'd4) r = d | s;
              else r = d ^ s;
              n.flags[`FLG_V] = 1'b0;
            end
            if (hi <= 4'd3) begin
              n.flags[`FLG_C] = w9[8];
              n.flags[`FLG_H] = h5[4];
            end
            n.flags[`FLG_Z] = (r == 8'h00);
            n.flags[`FLG_S] = r[7];
            n.wreg[ra] = r;
          end else if (lo == 4'hA) begin
            r = q.wreg[hi] - 8'h01;
            n.wreg[hi] = r;
            if (r != 8'h00) n.pc = q.pc + {{8{q.opa[7]}}, q.opa};
          end else if (lo == 4'hB) begin
            if (cond_true(hi, q.flags)) n.pc = q.pc + {{8{q.opa[7]}}, q.opa};
          end else if (lo == 4'hD) begin
            if (cond_true(hi, q.flags)) n.pc = {q.opa, q.opb};
          end else begin
            case (q.opc)
              `BYTE_MULTIPLY_OP: begin
                prod = q.wreg[rp] * q.wreg[rp + 4'd1];
                n.wreg[rp] = prod[15:8];
                n.wreg[rp + 4'd1] = prod[7:0];
              end
              `INTERRUPT_RETURN_OP: begin
                n.flags = q.mem[q.sp[3:0]][5:0];
                sp_t = q.sp + 16'h0001;
                n.pc = {q.mem[sp_t[3:0]], q.mem[sp_t[3:0] + 4'd1]};
                n.sp = q.sp + 16'h0003;
                n.irq_ctl[`IRQ_ENABLE_BIT] = 1'b1;
              end
              `OPC_TRAP: begin
                sp_t = q.sp - 16'h0002;
                n.mem[sp_t[3:0]] = q.pc[15:8];
                n.mem[sp_t[3:0] + 4'd1] = q.pc[7:0];
                sp_t = q.sp - 16'h0003;
                n.mem[sp_t[3:0]] = {2'b00, q.flags};
                n.sp = sp_t;
                n.pc = {q.mem[q.opa[3:0]], q.mem[q.opa[3:0] + 4'd1]};
              end
              `SUBROUTINE_RETURN_OP: begin
                n.pc = {q.mem[q.sp[3:0]], q.mem[q.sp[3:0] + 4'd1]};
                n.sp = q.sp + 16'h0002;
              end
              `OPC_POP, `EXTENDED_POP_OP: begin
                n.wreg[ra] = q.mem[q.sp[3:0]];
                n.sp = q.sp + 16'h0001;
              end
              `OPC_POP_IND: begin
                n.mem[q.wreg[ra][3:0]] = q.mem[q.sp[3:0]];
                n.sp = q.sp + 16'h0001;
              end
              `OPC_PUSH, `EXTENDED_PUSH_OP, `OPC_PUSH_IND: begin
                sp_t = q.sp - 16'h0001;
                s = (q.opc == `OPC_PUSH_IND) ? q.mem[q.wreg[ra][3:0]] : q.wreg[ra];
                n.mem[sp_t[3:0]] = s;
                n.sp = sp_t;
              end
              `OPC_PMOVE_TO, `OPC_DMOVE_TO, `OPC_PMOVE_FROM, `OPC_DMOVE_FROM: begin
                addr = {q.wreg[rp], q.wreg[rp + 4'd1]};
                if (q.opc[4]) n.mem[addr[3:0]] = q.mem[q.wreg[ra][3:0]];
                else n.mem[q.wreg[ra][3:0]] = q.mem[addr[3:0]];
                n.wreg[ra] = q.wreg[ra] + 8'h01;
                addr = addr + 16'h0001;
                n.wreg[rp] = addr[15:8];
                n.wreg[rp + 4'd1] = addr[7:0];
              end
              default: begin
                // Rotate and shift group, odd opcodes use the indirect operand.
                d = q.opc[0] ? q.mem[q.wreg[ra][3:0]] : q.wreg[ra];
                if (hi == 4'd1) begin
                  r = {d[6:0], q.flags[`FLG_C]};
                  n.flags[`FLG_C] = d[7];
                end else if (hi == 4'hD) begin
                  r = {d[7], d[7:1]};
                  n.flags[`FLG_C] = d[0];
                end else begin
                  r = {d[0], d[7:1]};
                  n.flags[`FLG_C] = d[0];
                end
                n.flags[`FLG_Z] = (r == 8'h00);
                n.flags[`FLG_S] = r[7];
                n.flags[`FLG_V] = (hi == 4'hD) ? 1'b0 : (d[7] ^ r[7]);
                if (q.opc[0]) n.mem[q.wreg[ra][3:0]] = r;
                else n.wreg[ra] = r;
              end
            endcase
          end
        end
      end
      default: begin
      end
    endcase

    // Bus slave: one wait cycle, then acknowledge with registered data.
    // A write lands only at the edge where the master sees waitrequest low.
    if (read_in || write_in) begin
      n.ack = ~q.ack;
      if (write_in && q.ack && q.fsm == cpu_exec_pkg::S_IDLE) begin
        // Writes during execution are dropped so operands stay stable.
        case (address_in)
          `OFS_CTRL: begin
            if (writedata_in[`CTRL_START_BIT]) begin
              n.done = 1'b0;
              n.illegal = 1'b0;
              n.last_cycles = {1'b0, tm[7:4]} + {1'b0, tm[3:0]};
              if (tm[8]) begin
                n.fsm = cpu_exec_pkg::S_FETCH;
                n.cnt = tm[7:4] - 4'd1;
                n.exec_cnt = tm[3:0];
              end else begin
                n.illegal = 1'b1;
                n.done = 1'b1;
              end
            end
          end
          `OFS_INSTR: begin
            n.opc = writedata_in[7:0];
            n.opa = writedata_in[15:8];
            n.opb = writedata_in[23:16];
            n.pfx = writedata_in[`INSTR_PREFIX_BIT];
          end
          `OFS_FLAGS: begin
            n.flags = writedata_in[5:0];
            n.irq_ctl = writedata_in[15:8];
          end
          `OFS_PC: n.pc = writedata_in[15:0];
          `OFS_SP: n.sp = writedata_in[15:0];
          default: begin
            if ((address_in & `WIN_MASK) == `OFS_WREG_BASE) n.wreg[roff[5:2]] = writedata_in[7:0];
            else if ((address_in & `WIN_MASK) == `OFS_MEM_BASE) n.mem[roff[5:2]] = writedata_in[7:0];
          end
        endcase
      end
      if (read_in && !q.ack) begin
        case (address_in)
          `OFS_INSTR: rv = {7'h00, q.pfx, q.opb, q.opa, q.opc};
          `OFS_STATUS: rv = {19'h0_0000, q.last_cycles, 5'h00,
                             q.illegal, q.done, (q.fsm != cpu_exec_pkg::S_IDLE)};
          `OFS_FLAGS: rv = {16'h0000, q.irq_ctl, 2'b00, q.flags};
          `OFS_PC: rv = {16'h0000, q.pc};
          `OFS_SP: rv = {16'h0000, q.sp};
          default: begin
            if ((address_in & `WIN_MASK) == `OFS_WREG_BASE) rv = {24'h00_0000, q.wreg[roff[5:2]]};
            else if ((address_in & `WIN_MASK) == `OFS_MEM_BASE) rv = {24'h00_0000, q.mem[roff[5:2]]};
          end
        endcase
        n.rdata = rv;
      end
    end
  end

  // One register for all state; the clock enable freezes everything.
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      q <= '0;
    end else if (ce_in) begin
      q <= n;
    end
  end

  // Outputs.
  assign readdata_out = q.rdata;
  assign waitrequest_out = (read_in | write_in) & ~q.ack;
  assign busy_out = (q.fsm != cpu_exec_pkg::S_IDLE);

endmodule

/* File: design/cpu_exec_defines.svh */
`ifndef CPU_EXEC_DEFINES_SVH
`define CPU_EXEC_DEFINES_SVH

// Register byte offsets on the Avalon-MM slave.
`define OFS_CTRL 8'h00
`define OFS_INSTR 8'h04
`define OFS_STATUS 8'h08
`define OFS_FLAGS 8'h0C
`define OFS_PC 8'h10
`define OFS_SP 8'h14
`define OFS_WREG_BASE 8'h40
`define OFS_MEM_BASE 8'h80
`define WIN_MASK 8'hC0

// Control and status fields.
`define CTRL_START_BIT 0
`define INSTR_PREFIX_BIT 24
`define STAT_BUSY_BIT 0
`define STAT_DONE_BIT 1
`define STAT_ILLEGAL_BIT 2
`define IRQ_ENABLE_BIT 7

// Flag bit positions within the six-bit flags byte.
`define FLG_C 5
`define FLG_Z 4
`define FLG_S 3
`define FLG_V 2
`define FLG_D 1
`define FLG_H 0

// Opcodes with fixed encodings.
`define OPC_PREFIX 8'h1F
`define BYTE_MULTIPLY_OP 8'hF4
`define INTERRUPT_RETURN_OP 8'hBF
`define OPC_TRAP 8'hF2
`define SUBROUTINE_RETURN_OP 8'hAF
`define OPC_POP 8'h50
`define OPC_POP_IND 8'h51
`define EXTENDED_POP_OP 8'hD8
`define OPC_PUSH 8'h70
`define OPC_PUSH_IND 8'h71
`define EXTENDED_PUSH_OP 8'hC8
`define OPC_PMOVE_TO 8'hC3
`define OPC_PMOVE_FROM 8'hD3
`define OPC_DMOVE_TO 8'h83
`define OPC_DMOVE_FROM 8'h93
`define OPC_SHL_LO 8'hC0
`define OPC_SHL_HI 8'hC1

// Cycle counts of the non-table instructions (execute only).
`define CYC_MULTIPLY_EX 4'd8
`define CYC_INT_RETURN_EX 4'd5
`define CYC_TRAP_EX 4'd6
`define CYC_SUB_RETURN_EX 4'd4
`define CYC_MOVE_EX 4'd9
`define CYC_ILLEGAL_EX 4'd2

`endif

/* File: design/cpu_exec_pkg.sv */
package cpu_exec_pkg;

  typedef enum logic [1:0] {
    S_IDLE,
    S_FETCH,
    S_EXEC
  } fsm_t;

  // Whole state of the execute unit, registered as one word.
  typedef struct packed {
    fsm_t fsm;
    logic [3:0] cnt;
    logic [3:0] exec_cnt;
    logic [15:0][7:0] wreg;
    logic [15:0][7:0] mem;
    logic [5:0] flags;
    logic [7:0] irq_ctl;
    logic [15:0] pc;
    logic [15:0] sp;
    logic [7:0] opc;
    logic [7:0] opa;
    logic [7:0] opb;
    logic pfx;
    logic done;
    logic illegal;
    logic [4:0] last_cycles;
    logic ack;
    logic [31:0] rdata;
  } state_t;

endpackage

/* File: bench/soft_host.sv */
`timescale 1ns/1ps
// Software side of the register bus; each request is held until waitrequest is seen low.
module soft_host (
  input wire logic clk_in, // Bus clock.
  input wire logic [31:0] readdata_in, // Slave read data.
  input wire logic waitrequest_in, // Slave stall.
  output logic [7:0] address_out, // Byte address.
  output logic read_out, // Read strobe.
  output logic write_out, // Write strobe.
  output logic [31:0] writedata_out // Write data.
);
  // Idle bus from time zero.
  initial begin
    address_out = 8'h00;
    read_out = 1'b0;
    write_out = 1'b0;
    writedata_out = 32'h0000_0000;
  end

  // One access; no answer time is assumed, so only the bench watchdog ends a wait.
  // Released address and write data lines show the inverse of the task's arguments so stale data is never mistaken for valid.
  task automatic xfer(input logic w, input logic [7:0] adr, input logic [31:0] wd, output logic [31:0] q);
    @(posedge clk_in);
    address_out <= adr;
    writedata_out <= w ? wd : ~wd;
    write_out <= w;
    read_out <= !w;
    do @(posedge clk_in); while (waitrequest_in !== 1'b0);
    q = readdata_in;
    address_out <= ~adr;
    writedata_out <= ~wd;
    write_out <= 1'b0;
    read_out <= 1'b0;
  endtask
endmodule

/* File: bench/cpu_exec_core_properties.sv */
`timescale 1ns/1ps
`include "cpu_exec_defines.svh"
// Watches the register bus and the busy line of the execute unit.
module cpu_exec_core_checker (
  input wire logic clk_in, // Clock.
  input wire logic rst_in, // Synchronous reset.
  input wire logic ce_in, // Clock enable.
  input wire logic [7:0] address_in, // Bus address.
  input wire logic read_in, // Bus read.
  input wire logic write_in, // Bus write.
  input wire logic [31:0] writedata_in, // Bus write data.
  input wire logic [31:0] readdata_out, // Bus read data.
  input wire logic waitrequest_out, // Bus stall.
  input wire logic busy_out // Instruction running.
);
  default clocking @(posedge clk_in);
  endclocking
  default disable iff (rst_in);

  // An access accepted by the slave.
  sequence s_acked;
    (read_in || write_in) && !waitrequest_out;
  endsequence
  // A start command accepted while idle.
  sequence s_start;
    s_acked ##0 (write_in && address_in == `OFS_CTRL && !busy_out);
  endsequence

  // Bus timing: one wait state, one acknowledge cycle, no stall while idle.
  a_one_wait: assert property ($rose(read_in || write_in) && ce_in |-> waitrequest_out ##1 !waitrequest_out)
    else $error("wait state count wrong");
  a_idle_no_stall: assert property (!(read_in || write_in) |-> !waitrequest_out)
    else $error("stall without request");
  a_ack_single: assert property (s_acked |=> !((read_in || write_in) && !waitrequest_out))
    else $error("acknowledge longer than one cycle");
  a_read_hold: assert property (!$stable(readdata_out) |-> $past(read_in))
    else $error("read data changed without read");
  a_unmapped_zero: assert property (s_acked ##0 (read_in && address_in inside {[8'h18:8'h3C]}) |->
    readdata_out == 32'h0000_0000) else $error("unmapped read not zero");
  // Instruction duration: busy starts right after a start and spans fetch plus execute.
  a_start_busy: assert property ($rose(busy_out) |-> $past(write_in && !waitrequest_out && address_in == `OFS_CTRL))
    else $error("busy rose without start");
  a_busy_min: assert property (s_start ##1 $rose(busy_out) |-> busy_out [*3])
    else $error("instruction shorter than three cycles");
  a_busy_max: assert property ($rose(busy_out) |-> ##[3:11] !busy_out)
    else $error("instruction longer than eleven cycles");
endmodule

bind cpu_exec_core cpu_exec_core_checker u_checker (.clk_in(clk_in), .rst_in(rst_in), .ce_in(ce_in),
  .address_in(address_in), .read_in(read_in), .write_in(write_in), .writedata_in(writedata_in),
  .readdata_out(readdata_out), .waitrequest_out(waitrequest_out), .busy_out(busy_out));

/* File: bench/cpu_exec_core_tb.sv */
`timescale 1ns/1ps
`include "cpu_exec_defines.svh"
module cpu_exec_core_tb;
  logic clk_in;
  logic rst_in;
  logic ce_in;
  logic [7:0] address_in;
  logic read_in;
  logic write_in;
  logic [31:0] writedata_in;
  logic [31:0] readdata_out;
  logic waitrequest_out;
  logic busy_out;
  int err_total;
  int checks_done;
  logic [31:0] seed;
  logic [31:0] rd;
  logic [7:0] r [16];
  logic [7:0] a;
  logic [7:0] op;
  logic [5:0] f;
  logic [13:0] e;
  logic [15:0] p;
  logic [7:0] ops [13] = '{8'h02, 8'h12, 8'h22, 8'h32, 8'h52, 8'h08, 8'h18, 8'h38, 8'h58, 8'h10, 8'hD0, 8'hE0, 8'hC0};

  cpu_exec_core u_dut (.clk_in(clk_in), .rst_in(rst_in), .ce_in(ce_in), .address_in(address_in),
    .read_in(read_in), .write_in(write_in), .writedata_in(writedata_in), .readdata_out(readdata_out),
    .waitrequest_out(waitrequest_out), .busy_out(busy_out));
  soft_host u_host (.clk_in(clk_in), .readdata_in(readdata_out), .waitrequest_in(waitrequest_out),
    .address_out(address_in), .read_out(read_in), .write_out(write_in), .writedata_out(writedata_in));

  // Free-running 100 MHz clock.
  initial begin
    clk_in = 1'b0;
    forever #5 clk_in = ~clk_in;
  end

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic [7:0] wa(input int i);
    return 8'(`OFS_WREG_BASE + 4 * i);
  endfunction
  function automatic logic [7:0] ma(input int i);
    return 8'(`OFS_MEM_BASE + 4 * i);
  endfunction
  // Reference arithmetic: result byte then flags {C,Z,S,V,D,H}.
  function automatic logic [13:0] alu(input logic [7:0] op, d, s, input logic [5:0] fi);
    logic [8:0] y;
    logic [4:0] h;
    logic ci;
    logic sb;
    ci = op[4] & fi[5];
    sb = op[7:5] == 3'b001;
    y = sb ? {1'b0, d} - {1'b0, s} - 9'(ci) : {1'b0, d} + {1'b0, s} + 9'(ci);
    h = sb ? {1'b0, d[3:0]} - {1'b0, s[3:0]} - 5'(ci) : {1'b0, d[3:0]} + {1'b0, s[3:0]} + 5'(ci);
    if (op[7:4] == 4'h5) begin
      return {d & s, fi[5], (d & s) == 8'h00, d[7] & s[7], 1'b0, fi[1:0]};
    end
    return {y[7:0], y[8], y[7:0] == 8'h00, y[7], ~(d[7] ^ s[7] ^ sb) & (y[7] ^ d[7]), sb, h[4]};
  endfunction
  // Reference rotates and shifts; D and H are carried through.
  function automatic logic [13:0] shf(input logic [7:0] op, d, input logic [5:0] fi);
    logic [7:0] y;
    case (op)
      8'h10: y = {d[6:0], fi[5]};
      8'hD0: y = {d[7], d[7:1]};
      8'hE0: y = {d[0], d[7:1]};
      default: y = {1'b0, d[7:1]};
    endcase
    return {y, op == 8'h10 ? d[7] : d[0], y == 8'h00, y[7], op == 8'hD0 ? 1'b0 : d[7] ^ y[7], fi[1:0]};
  endfunction
  // Condition test; the upper half of the codes is the inverse of the lower half.
  function automatic logic cond(input logic [3:0] cc, input logic [5:0] fl);
    logic [7:0] t;
    t = {fl[5], fl[4], fl[3], fl[2], fl[5] | fl[4], fl[4] | (fl[3] ^ fl[2]), fl[3] ^ fl[2], 1'b0};
    return t[cc[2:0]] ^ cc[3];
  endfunction

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_total++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] ad, input logic [31:0] d);
    u_host.xfer(1'b1, ad, d, rd);
  endtask
  task automatic rdc(input logic [7:0] ad, input logic [31:0] exp);
    u_host.xfer(1'b0, ad, 32'h0000_0000, rd);
    chk(rd, exp);
  endtask
  task automatic setr(input int i, input logic [7:0] v);
    r[i] = v;
    wr(wa(i), {24'h00_0000, v});
  endtask
  // Loads and starts one instruction, waits for completion, then checks done and the cycle count.
  task automatic run(input logic [24:0] ins, input int cyc);
    wr(`OFS_INSTR, {7'h00, ins});
    wr(`OFS_CTRL, 32'h0000_0001);
    @(negedge clk_in);
    chk({31'h0, busy_out}, 32'h0000_0001);
    do u_host.xfer(1'b0, `OFS_STATUS, 32'h0000_0000, rd); while (rd[0] !== 1'b0);
    chk(rd, {19'h0_0000, 5'(cyc), 8'h02});
  endtask
  task automatic stop_test();
    $display("Counts: %0d comparisons, %0d mismatches", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // The run needs some two thousand five hundred cycles; the watchdog allows fifty thousand.
  initial begin
    #500_000;
    err_total++;
    stop_test();
  end

  // Main sequence.
  initial begin
    seed = 32'h251a_54c4;
    err_total = 0;
    checks_done = 0;
    rst_in = 1'b1;
    ce_in = 1'b1;
    repeat (16) @(posedge clk_in);
    rst_in <= 1'b0;
    rdc(`OFS_FLAGS, 32'h0000_0000);
    rdc(`OFS_SP, 32'h0000_0000);
    wr(8'h24, 32'hFFFF_FFFF);
    rdc(8'h24, 32'h0000_0000);
    wr(`OFS_INSTR, 32'h0000_0001);
    wr(`OFS_CTRL, 32'h0000_0001);
    rdc(`OFS_STATUS, 32'h0000_0306);
    $display("reset and unmapped test done");
    for (int k = 0; k < 52; k++) begin
      op = ops[k % 13];
      f = 6'(rnd());
      a = 8'(rnd());
      setr(1, 8'(rnd()));
      setr(2, 8'(rnd()));
      wr(`OFS_FLAGS, {26'h0, f});
      e = (k % 13 < 9) ? alu(op, r[1], op[3] ? a : r[2], f) : shf(op, r[1], f);
      run({op == 8'hC0, a, 8'h12, op}, (k % 13 < 9) ? (op[3] ? 7 : 5) : (op == 8'hC0 ? 5 : 4));
      rdc(wa(1), {24'h00_0000, e[13:6]});
      rdc(`OFS_FLAGS, {26'h0, e[5:0]});
    end
    $display("arithmetic and shift test done");
    setr(4, 8'(rnd()));
    setr(5, 8'(rnd()));
    run({1'b0, 8'h00, 8'h44, `BYTE_MULTIPLY_OP}, 10);
    p = r[4] * r[5];
    rdc(wa(4), {24'h00_0000, p[15:8]});
    rdc(wa(5), {24'h00_0000, p[7:0]});
    rdc(`OFS_FLAGS, {26'h0, e[5:0]});
    for (int k = 0; k < 34; k++) begin
      f = 6'(rnd());
      a = 8'(rnd());
      p = 16'(rnd());
      wr(`OFS_FLAGS, {26'h0, f});
      wr(`OFS_PC, {16'h0000, p});
      if (k > 31) begin
        setr(6, 8'(k - 31));
        run({1'b0, 8'h00, a, 8'h6A}, 5);
        rdc(wa(6), 32'(k - 32));
        rdc(`OFS_PC, {16'h0000, k > 32 ? p + {{8{a[7]}}, a} : p});
      end else begin
        run({1'b0, 8'h77, a, k[3:0], k[4] ? 4'hD : 4'hB}, k[4] ? 5 : 4);
        p = cond(k[3:0], f) ? (k[4] ? {a, 8'h77} : p + {{8{a[7]}}, a}) : p;
        rdc(`OFS_PC, {16'h0000, p});
      end
      rdc(`OFS_FLAGS, {26'h0, f});
    end
    $display("branch test done");
    wr(ma(2), 32'h0000_00C3);
    wr(ma(3), 32'h0000_0021);
    wr(`OFS_SP, 32'h0000_0008);
    wr(`OFS_PC, 32'h0000_1234);
    run({1'b0, 8'h00, 8'h02, `OPC_TRAP}, 8);
    rdc(`OFS_PC, 32'h0000_C321);
    rdc(`OFS_SP, 32'h0000_0005);
    rdc(ma(6), 32'h0000_0012);
    rdc(ma(7), 32'h0000_0034);
    u_host.xfer(1'b0, ma(5), 32'h0000_0000, rd);
    chk({26'h0, rd[5:0]}, {26'h0, f});
    wr(`OFS_FLAGS, 32'h0000_0000);
    run({1'b0, 16'h0000, `INTERRUPT_RETURN_OP}, 6);
    rdc(`OFS_FLAGS, {16'h0000, 8'h80, 2'b00, f});
    rdc(`OFS_PC, 32'h0000_1234);
    rdc(`OFS_SP, 32'h0000_0008);
    wr(ma(8), 32'h0000_0056);
    wr(ma(9), 32'h0000_0078);
    run({1'b0, 16'h0000, `SUBROUTINE_RETURN_OP}, 5);
    rdc(`OFS_PC, 32'h0000_5678);
    rdc(`OFS_SP, 32'h0000_000A);
    setr(3, 8'(rnd()));
    run({1'b0, 8'h00, 8'h30, `OPC_PUSH}, 4);
    rdc(`OFS_SP, 32'h0000_0009);
    rdc(ma(9), {24'h00_0000, r[3]});
    run({1'b0, 8'h00, 8'h70, `OPC_POP}, 4);
    rdc(wa(7), {24'h00_0000, r[3]});
    rdc(`OFS_SP, 32'h0000_000A);
    setr(1, 8'h04);
    setr(2, 8'h00);
    setr(3, 8'h0A);
    wr(ma(10), 32'h0000_005D);
    run({1'b0, 8'h00, 8'h12, `OPC_PMOVE_TO}, 11);
    rdc(ma(4), 32'h0000_005D);
    rdc(wa(1), 32'h0000_0005);
    rdc(wa(3), 32'h0000_000B);
    $display("stack and block move test done");
    stop_test();
  end
endmodule
